// *** brc_pkg.sv ***
// Package with register map, field layout and timing of the buck control
package brc_pkg;
    localparam int NCONV = 6;
    localparam int CW    = 8;
    localparam int DW    = 16;
    localparam int AW    = 8;
    localparam int NPIN  = 3;
    localparam int SW    = 4;
    localparam int CTRLW = 14;

    // Register offsets
    localparam logic [AW-1:0] ADDR_GLOBAL   = 8'h00;
    localparam logic [AW-1:0] ADDR_STATUS   = 8'h01;
    localparam logic [AW-1:0] ADDR_CTRL     = 8'h10;
    localparam logic [AW-1:0] ADDR_VOLT_A   = 8'h80;
    localparam logic [AW-1:0] ADDR_VOLT_B   = 8'h88;
    localparam logic [AW-1:0] ADDR_LOCK_MAX = 8'h7f;

    // Global register fields
    localparam int G_LOCK = 0;
    localparam int G_SOFT = 1;
    localparam int G_DEFS = 2;
    localparam int G_RDY  = 3;
    localparam int G_SLEW = 4;
    localparam logic [DW-1:0] GLOBAL_RST = 16'h0000;

    // Status register fields
    localparam int S_RAMP = 0;
    localparam int S_DONE = 6;
    localparam int S_PINS = 7;
    localparam int S_PFM  = 10;

    // Voltage code scale: code 0 is the base, one code per step
    localparam int VBASE_MV     = 300;
    localparam int VSTEP_MV     = 10;
    localparam int PFM_FLOOR_MV = 700;
    localparam logic [CW-1:0] PFM_FLOOR_CODE =
        CW'((PFM_FLOOR_MV - VBASE_MV) / VSTEP_MV);
    localparam logic [CW-1:0] VOLT_RST = 8'h46;

    // Timing at the reference clock
    localparam int CLK_NS   = 10;
    localparam int SLEW0_NS = 4000;
    localparam int SLEW1_NS = 2000;
    localparam int SLEW2_NS = 1000;
    localparam int SLEW3_NS = 500;
    localparam int SLW      = 9;
    localparam logic [SLW-1:0] SLEW0_RLD = SLW'(SLEW0_NS / CLK_NS - 1);
    localparam logic [SLW-1:0] SLEW1_RLD = SLW'(SLEW1_NS / CLK_NS - 1);
    localparam logic [SLW-1:0] SLEW2_RLD = SLW'(SLEW2_NS / CLK_NS - 1);
    localparam logic [SLW-1:0] SLEW3_RLD = SLW'(SLEW3_NS / CLK_NS - 1);
    localparam int SOFT_START_US  = 3000;
    localparam int SOFT_START_CYC = SOFT_START_US * 1000 / CLK_NS;
    localparam int SSW            = 19;

    // Operating modes and pin sources
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_PFM  = 2'h1;
    localparam logic [1:0] MODE_PWM  = 2'h2;
    localparam logic [1:0] SRC_NONE  = 2'h0;

    // Per-converter control register
    typedef struct packed {
        logic [SW-1:0] slot;
        logic [1:0]    vsrc;
        logic [1:0]    esrc;
        logic          pd_dis;
        logic          keep_on;
        logic [1:0]    mode;
        logic          sel;
        logic          en;
    } brc_ctrl_s;

    localparam brc_ctrl_s CTRL_RST = '0;
endpackage

// *** brc_ramp_unit.sv ***
// Ramp engine stepping one converter's output code toward its target
module brc_ramp_unit (
    input  wire logic                   ref_clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   en_i,
    input  wire logic                   tick_i,
    input  wire logic [brc_pkg::CW-1:0] target_i,
    output logic      [brc_pkg::CW-1:0] code_o,
    output logic                        ramping_o,
    output logic                        pfm_hold_o
);
    localparam int CW = brc_pkg::CW;

    logic [CW-1:0] code;
    logic [CW-1:0] next_code;

    // Reductions below the floor end the controlled ramp at the floor
    wire below = target_i < brc_pkg::PFM_FLOOR_CODE;
    wire [CW-1:0] goal = below ? brc_pkg::PFM_FLOOR_CODE : target_i;
    wire in_pfm = below && code <= brc_pkg::PFM_FLOOR_CODE;
    wire move = en_i && !in_pfm && code != goal;

    assign next_code = !en_i ? target_i :
                       in_pfm ? target_i :
                       !(move && tick_i) ? code :
                       code < goal ? code + 8'h01 :
                       code - 8'h01;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            code <= brc_pkg::VOLT_RST;
        end else begin
            code <= next_code;
        end
    end

    assign code_o     = code;
    assign ramping_o  = move;
    assign pfm_hold_o = en_i && below;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    property p_step;
        en_i && tick_i && move && $stable(en_i)
            |=> (code == $past(code) + 8'h01)
                || (code == $past(code) - 8'h01);
    endproperty
    a_step: assert property (p_step)
        else $error("Ramp did not move exactly one code");

    property p_floor;
        en_i && below && code > brc_pkg::PFM_FLOOR_CODE && tick_i
            ##1 en_i && below |-> code >= brc_pkg::PFM_FLOOR_CODE;
    endproperty
    a_floor: assert property (p_floor)
        else $error("Ramp passed below the floor");

    property p_stop;
        en_i && !below && code == target_i ##1 $stable(target_i) && en_i
            |-> !ramping_o && code == target_i;
    endproperty
    a_stop: assert property (p_stop)
        else $error("Ramp left its target");
endmodule  // brc_ramp_unit

// *** brc_buck_ctrl.sv ***
// Control logic for six step-down converters with ramped voltage change
//
// Notes on behaviour
// - Soft-start limits current for 3 ms after enable
// - Voltage codes step by 10 mV each
// - Ready port driven while ramping; done event after
// - Falls below 0.7 V stop there, go PFM
// - Writing selected setting ramps toward it at once
// - Writing unselected setting only stores; select toggles ramp
// - One code per 4, 2, 1, 0.5 us
// - Mode field picks PWM, PFM or automatic
// - On and select writes apply, except that reset mode holds on cleared; reads live
// - Slot zero defaults applied as sequencer passes slot
// - Power-up clears select for matching slot converters
// - Power-down disables, keep-on ones select alternate setting
// - Wake reload restores primary settings to defaults
// - Pin fields bind enable or select to pins
// - Pin edges apply level; edge event self-clears
// - Host control write during pin update applies after
// - Sequencer skips settings under pin control
// - Reset mode forces every converter off
// - Disabled converter pulls output down unless disabled
// - Lock blocks writes above 0x7F
module brc_buck_ctrl #(
    parameter int SOFT_START_CYC = brc_pkg::SOFT_START_CYC
) (
    input  wire logic                                   ref_clk_i,
    input  wire logic                                   arst_n_i,
    input  wire logic [brc_pkg::AW-1:0]                 reg_addr_i,
    input  wire logic [brc_pkg::DW-1:0]                 reg_wdata_i,
    input  wire logic                                   reg_wr_i,
    input  wire logic                                   reg_rd_i,
    output logic      [brc_pkg::DW-1:0]                 reg_rdata_o,
    input  wire logic                                   seq_up_i,
    input  wire logic                                   seq_down_i,
    input  wire logic [brc_pkg::SW-1:0]                 seq_slot_i,
    input  wire logic                                   seq_otp_reload_i,
    input  wire logic                                   reset_mode_i,
    input  wire logic                                   ldo_ramping_i,
    input  wire logic [brc_pkg::NCONV-1:0]              load_high_i,
    input  wire logic [brc_pkg::NPIN-1:0]               control_pin_i,
    output logic [brc_pkg::NCONV-1:0][brc_pkg::CW-1:0]  vout_code_o,
    output logic      [brc_pkg::NCONV-1:0]              conv_on_o,
    output logic      [brc_pkg::NCONV-1:0]              pwm_mode_o,
    output logic      [brc_pkg::NCONV-1:0]              inrush_limit_o,
    output logic      [brc_pkg::NCONV-1:0]              pulldown_o,
    output logic                                        ready_feedback_port_o,
    output logic                                        ready_feedback_port_oe_o,
    output logic                                        ramp_done_event_o
);
    localparam int N   = brc_pkg::NCONV;
    localparam int CW  = brc_pkg::CW;
    localparam int DW  = brc_pkg::DW;
    localparam int NP  = brc_pkg::NPIN;
    localparam int SSW = brc_pkg::SSW;

    logic [DW-1:0]          glb;
    logic                   done;
    logic                   any_q;
    logic [NP-1:0]          pin_s1;
    logic [NP-1:0]          pin_s2;
    logic [NP-1:0]          pin_s3;
    logic                   pend_v;
    logic [2:0]             pend_idx;
    logic [DW-1:0]          pend_data;
    logic [brc_pkg::SLW-1:0] slew_cnt;
    logic                   rdy;
    logic                   rdy_oe;
    logic [DW-1:0]          rdata;

    brc_pkg::brc_ctrl_s     ctrl_v [N];
    logic [CW-1:0]          va_v [N];
    logic [CW-1:0]          vb_v [N];
    logic [N-1:0]           ramping;
    logic [N-1:0]           pfm_hold;

    // Address decode and write qualification
    wire       lock     = glb[brc_pkg::G_LOCK];
    wire [1:0] slew_sel = glb[brc_pkg::G_SLEW +: 2];
    wire [2:0] idx      = reg_addr_i[2:0];
    wire       idx_ok   = idx < 3'(N);
    wire hit_glb  = reg_addr_i == brc_pkg::ADDR_GLOBAL;
    wire hit_sts  = reg_addr_i == brc_pkg::ADDR_STATUS;
    wire hit_ctrl = reg_addr_i[7:3] == brc_pkg::ADDR_CTRL[7:3] && idx_ok;
    wire hit_va   = reg_addr_i[7:3] == brc_pkg::ADDR_VOLT_A[7:3] && idx_ok;
    wire hit_vb   = reg_addr_i[7:3] == brc_pkg::ADDR_VOLT_B[7:3] && idx_ok;
    wire locked   = lock && reg_addr_i > brc_pkg::ADDR_LOCK_MAX;
    wire wr_ok    = reg_wr_i && !locked;

    // Pin edges: each pulse is the pin's edge event, gone next cycle
    wire [NP-1:0] edge_p = pin_s2 ^ pin_s3;
    wire pin_apply = |edge_p;
    wire ctrl_wr   = wr_ok && hit_ctrl;
    wire hold_wr   = ctrl_wr && pin_apply;
    wire any_ramp  = (|ramping) || ldo_ramping_i;
    wire done_set  = any_q && !any_ramp;
    wire done_clr  = wr_ok && hit_sts && reg_wdata_i[brc_pkg::S_DONE];

    // Shared slew interval
    wire tick = slew_cnt == '0;
    wire [brc_pkg::SLW-1:0] slew_rld =
        slew_sel == 2'h0 ? brc_pkg::SLEW0_RLD :
        slew_sel == 2'h1 ? brc_pkg::SLEW1_RLD :
        slew_sel == 2'h2 ? brc_pkg::SLEW2_RLD :
        brc_pkg::SLEW3_RLD;
    wire [brc_pkg::SLW-1:0] next_slew = tick ? slew_rld : slew_cnt - 9'h001;

    wire [DW-1:0] sts = {pfm_hold, pin_s2, done, ramping};
    wire [DW-1:0] rd_val =
        hit_glb  ? glb :
        hit_sts  ? sts :
        hit_ctrl ? DW'(ctrl_v[idx]) :
        hit_va   ? DW'(va_v[idx]) :
        hit_vb   ? DW'(vb_v[idx]) :
        '0;
    wire [DW-1:0] next_glb  = (wr_ok && hit_glb) ? reg_wdata_i : glb;
    wire          next_done = done_set || (done && !done_clr);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= control_pin_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            glb      <= brc_pkg::GLOBAL_RST;
            done     <= 1'b0;
            any_q    <= 1'b0;
            slew_cnt <= '0;
        end else begin
            glb      <= next_glb;
            done     <= next_done;
            any_q    <= any_ramp;
            slew_cnt <= next_slew;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend_v    <= 1'b0;
            pend_idx  <= '0;
            pend_data <= '0;
        end else begin
            pend_v    <= hold_wr;
            pend_idx  <= idx;
            pend_data <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata  <= '0;
            rdy    <= 1'b0;
            rdy_oe <= 1'b0;
        end else begin
            rdata  <= reg_rd_i ? rd_val : '0;
            rdy    <= any_ramp;
            rdy_oe <= glb[brc_pkg::G_RDY];
        end
    end

    assign reg_rdata_o              = rdata;
    assign ready_feedback_port_o    = rdy;
    assign ready_feedback_port_oe_o = rdy_oe;
    assign ramp_done_event_o        = done;

    for (genvar i = 0; i < N; i++) begin : g_conv
        brc_pkg::brc_ctrl_s ctrl;
        brc_pkg::brc_ctrl_s nxt;
        logic [CW-1:0]      va;
        logic [CW-1:0]      vb;
        logic               en_q;
        logic [SSW-1:0]     ss_cnt;
        logic               pwm;
        logic               pd;
        logic [CW-1:0]      code;

        wire me = idx == 3'(i);
        // Pin bindings, source 1..3 names pin one, two, three
        wire [1:0] es = ctrl.esrc - 2'h1;
        wire [1:0] vs = ctrl.vsrc - 2'h1;
        wire e_pin = ctrl.esrc != brc_pkg::SRC_NONE;
        wire v_pin = ctrl.vsrc != brc_pkg::SRC_NONE;
        wire pe_hit = e_pin && edge_p[es];
        wire pv_hit = v_pin && edge_p[vs];
        wire slot_hit = ctrl.slot == seq_slot_i;
        wire up_on = seq_slot_i != '0 || glb[brc_pkg::G_DEFS];
        wire wr_me = ctrl_wr && !pin_apply && me;
        wire pend_me = pend_v && pend_idx == 3'(i);

        always_comb begin
            nxt = ctrl;
            if (seq_up_i && slot_hit) begin
                if (!e_pin) nxt.en = up_on;
                if (!v_pin && up_on) nxt.sel = 1'b0;
            end
            if (seq_down_i && slot_hit) begin
                if (ctrl.keep_on && !v_pin) nxt.sel = 1'b1;
                if (!ctrl.keep_on && !e_pin) nxt.en = 1'b0;
            end
            if (pe_hit) nxt.en = pin_s2[es];
            if (pv_hit) nxt.sel = pin_s2[vs];
            if (pend_me) begin
                nxt = brc_pkg::brc_ctrl_s'(pend_data[brc_pkg::CTRLW-1:0]);
            end
            if (wr_me) begin
                nxt = brc_pkg::brc_ctrl_s'(reg_wdata_i[brc_pkg::CTRLW-1:0]);
            end
            if (reset_mode_i) nxt.en = 1'b0;
        end

        // Voltage settings: host writes win over the wake reload
        wire [CW-1:0] next_va = (wr_ok && hit_va && me) ? reg_wdata_i[CW-1:0] :
                          seq_otp_reload_i ? brc_pkg::VOLT_RST : va;
        wire [CW-1:0] next_vb = (wr_ok && hit_vb && me) ? reg_wdata_i[CW-1:0] : vb;
        // Selected setting is the ramp target
        wire [CW-1:0] target = ctrl.sel ? vb : va;

        wire ss_go = ctrl.en && !en_q && glb[brc_pkg::G_SOFT];
        wire [SSW-1:0] next_ss = ss_go ? SSW'(SOFT_START_CYC) :
                           ss_cnt != '0 ? ss_cnt - 19'h0_0001 : ss_cnt;
        wire next_pwm = pfm_hold[i] ? 1'b0 :
                        ctrl.mode == brc_pkg::MODE_PWM ? 1'b1 :
                        ctrl.mode == brc_pkg::MODE_PFM ? 1'b0 :
                        load_high_i[i];
        wire next_pd = !ctrl.en && !ctrl.pd_dis;

        always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                ctrl <= brc_pkg::CTRL_RST;
                va   <= brc_pkg::VOLT_RST;
                vb   <= brc_pkg::VOLT_RST;
            end else begin
                ctrl <= nxt;
                va   <= next_va;
                vb   <= next_vb;
            end
        end

        always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                en_q   <= 1'b0;
                ss_cnt <= '0;
                pwm    <= 1'b0;
                pd     <= 1'b0;
            end else begin
                en_q   <= ctrl.en;
                ss_cnt <= next_ss;
                pwm    <= next_pwm;
                pd     <= next_pd;
            end
        end

        brc_ramp_unit u_ramp (
            .ref_clk_i  (ref_clk_i),
            .arst_n_i   (arst_n_i),
            .en_i       (ctrl.en),
            .tick_i     (tick),
            .target_i   (target),
            .code_o     (code),
            .ramping_o  (ramping[i]),
            .pfm_hold_o (pfm_hold[i])
        );

        assign ctrl_v[i]         = ctrl;
        assign va_v[i]           = va;
        assign vb_v[i]           = vb;
        assign vout_code_o[i]    = code;
        assign conv_on_o[i]      = ctrl.en;
        assign pwm_mode_o[i]     = pwm;
        assign inrush_limit_o[i] = ss_cnt != '0;
        assign pulldown_o[i]     = pd;
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    property p_off;
        reset_mode_i |=> conv_on_o == '0;
    endproperty
    a_off: assert property (p_off)
        else $error("Converter on during reset mode");

    property p_lock;
        lock && reg_wr_i && hit_va && !seq_otp_reload_i
            |=> va_v[$past(idx)] == $past(va_v[idx]);
    endproperty
    a_lock: assert property (p_lock)
        else $error("Locked voltage setting changed");

    property p_ready;
        glb[brc_pkg::G_RDY] && any_ramp
            |=> ready_feedback_port_o && ready_feedback_port_oe_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("Ready port not driven while ramping");

    property p_done;
        done_set |=> ramp_done_event_o
            ##1 (ramp_done_event_o || $past(done_clr));
    endproperty
    a_done: assert property (p_done)
        else $error("Ramp done event missing");

    property p_soft;
        ctrl_v[0].en && !g_conv[0].en_q && glb[brc_pkg::G_SOFT]
            |=> inrush_limit_o[0] [*8];
    endproperty
    a_soft: assert property (p_soft)
        else $error("Soft-start limit ended early");

    property p_pend;
        hold_wr ##1 (!reg_wr_i && !reset_mode_i)
            |=> ctrl_v[$past(idx, 2)] == brc_pkg::brc_ctrl_s'(
                    $past(reg_wdata_i[brc_pkg::CTRLW-1:0], 2));
    endproperty
    a_pend: assert property (p_pend)
        else $error("Held control write not applied");

    property p_seq_pin;
        seq_up_i && ctrl_v[4].esrc != brc_pkg::SRC_NONE && !pin_apply
            && !reg_wr_i && !pend_v && !reset_mode_i
            |=> ctrl_v[4].en == $past(ctrl_v[4].en);
    endproperty
    a_seq_pin: assert property (p_seq_pin)
        else $error("Sequencer changed pin-controlled enable");

    property p_pd;
        !conv_on_o[0] && !ctrl_v[0].pd_dis && $stable(ctrl_v[0])
            |=> pulldown_o[0];
    endproperty
    a_pd: assert property (p_pd)
        else $error("Pull-down off for disabled converter");

    property p_pfm;
        pfm_hold[0] ##1 pfm_hold[0] |-> !pwm_mode_o[0];
    endproperty
    a_pfm: assert property (p_pfm)
        else $error("Converter not in PFM below floor");

    property p_wr;
        ctrl_wr && !pin_apply && !reset_mode_i
            |=> ctrl_v[$past(idx)].en == $past(reg_wdata_i[0]);
    endproperty
    a_wr: assert property (p_wr)
        else $error("Host enable write not applied");
endmodule  // brc_buck_ctrl

// *** brc_host_model.sv ***
// Host model issuing register reads and writes to the buck control
module brc_host_model (
    input  wire logic                   ref_clk_i,
    output logic      [brc_pkg::AW-1:0] reg_addr_o,
    output logic      [brc_pkg::DW-1:0] reg_wdata_o,
    output logic                        reg_wr_o,
    output logic                        reg_rd_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 16'h0000;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    // One-cycle write strobe beside address and data
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o    <= 1'b0;
    endtask

    // One-cycle read strobe; data follow in the next cycle
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b0;
    endtask
endmodule // brc_host_model

// *** testbench.sv ***
// Self-checking bench for the buck control logic
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SS = 20;
    logic                ref_clk_i, arst_n_i, wr, rd, rd_d;
    logic [7:0]          addr;
    logic [15:0]         wdata, rdata;
    logic                up, down, otp, rmode, rfp, rfp_oe, done, ldo;
    logic [3:0]          slot;
    logic [2:0]          pin;
    logic [5:0]          load, on, pwm, inr, pd;
    logic [5:0][7:0]     code;
    logic [15:0]         exp_q[$];
    int                  error_cnt, checks, n;
    integer              seed;

    brc_host_model host (.ref_clk_i(ref_clk_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    brc_buck_ctrl #(.SOFT_START_CYC(SS)) dut (.ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .seq_up_i(up), .seq_down_i(down), .seq_slot_i(slot),
        .seq_otp_reload_i(otp), .reset_mode_i(rmode),
        .ldo_ramping_i(ldo), .load_high_i(load), .control_pin_i(pin),
        .vout_code_o(code), .conv_on_o(on), .pwm_mode_o(pwm),
        .inrush_limit_o(inr), .pulldown_o(pd),
        .ready_feedback_port_o(rfp), .ready_feedback_port_oe_o(rfp_oe),
        .ramp_done_event_o(done));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read data are watched here against the noted expectation
    always @(posedge ref_clk_i) rd_d <= rd;
    always @(negedge ref_clk_i)
        if (rd_d === 1'b1) chk(rdata, exp_q.pop_front());

    task automatic rx(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask

    // Cycles until converter 0 changes code
    task automatic gap;
        logic [7:0] c;
        c = code[0];
        n = 0;
        while (code[0] === c && n < 4000) begin
            cyc(1);
            n++;
        end
        if (n >= 4000) begin
            error_cnt++;
            summarize();
        end
    endtask

    task automatic wait_code(input logic [7:0] c);
        n = 0;
        while (code[0] !== c) begin
            cyc(1);
            n++;
            if (n > 4000) begin
                error_cnt++;
                summarize();
            end
        end
    endtask

    task automatic seq(input logic u, input logic [3:0] s);
        @(posedge ref_clk_i);
        up   <= u;
        down <= !u;
        slot <= s;
        @(posedge ref_clk_i);
        up   <= 1'b0;
        down <= 1'b0;
        cyc(2);
    endtask

    // Pin change off the clock edge, at the pin's own pace
    task automatic pin_set(input logic v);
        #62.5 pin[0] = v;
        cyc(8);
        chk(16'(on[4]), 16'(v));
    endtask

    initial begin
        seed = 32'h2c56ef1c;
        {arst_n_i, up, down, otp, rmode, slot, pin, load, ldo} = '0;
        error_cnt = 0;
        checks = 0;
        repeat (8) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        cyc(3);
        chk(16'(code[0]), 16'h0046);
        rx(brc_pkg::ADDR_VOLT_A, 16'h0046);
        host.wr(brc_pkg::ADDR_GLOBAL, 16'h003a);
        host.wr(brc_pkg::ADDR_CTRL, 16'h0009);
        host.wr(brc_pkg::ADDR_CTRL + 8'h05, 16'h0020);
        cyc(3);
        chk(16'(on), 16'h0001);
        chk(16'(inr[0]), 16'h0001);
        chk(16'(pwm[0]), 16'h0001);
        chk(16'(pd), 16'h001e);
        cyc(SS);
        chk(16'(inr[0]), 16'h0000);
        host.wr(brc_pkg::ADDR_VOLT_A, 16'h0049);
        host.wr(brc_pkg::ADDR_STATUS, 16'h0040);
        cyc(2);
        chk(16'({rfp, rfp_oe}), 16'h0003);
        rx(brc_pkg::ADDR_STATUS, 16'h0001);
        gap();
        gap();
        chk(16'(n), 16'd50);
        wait_code(8'h49);
        cyc(3);
        chk(16'({rfp, code[0]}), 16'h0049);
        rx(brc_pkg::ADDR_STATUS, 16'h0040);
        host.wr(brc_pkg::ADDR_STATUS, 16'h0040);
        @(posedge ref_clk_i) ldo <= 1'b1;
        cyc(2);
        chk(16'({rfp, done}), 16'h0002);
        @(posedge ref_clk_i) ldo <= 1'b0;
        cyc(2);
        chk(16'({rfp, done}), 16'h0001);
        host.wr(brc_pkg::ADDR_VOLT_B, 16'h004b);
        cyc(120);
        chk(16'(code[0]), 16'h0049);
        host.wr(brc_pkg::ADDR_CTRL, 16'h000b);
        wait_code(8'h4b);
        chk(16'(code[0]), 16'h004b);
        host.wr(brc_pkg::ADDR_VOLT_B, 16'h0010);
        wait_code(8'h10);
        cyc(3);
        chk(16'(pwm[0]), 16'h0000);
        rx(brc_pkg::ADDR_STATUS, 16'h0440);
        host.wr(brc_pkg::ADDR_GLOBAL, 16'h003b);
        host.wr(brc_pkg::ADDR_VOLT_A, 16'h0055);
        rx(brc_pkg::ADDR_VOLT_A, 16'h0049);
        rx(8'h20, 16'h0000);
        for (int m = 0; m < 3; m++) begin
            @(posedge ref_clk_i) load <= 6'($random(seed));
            host.wr(brc_pkg::ADDR_CTRL + 8'h01, 16'(m * 4 + 1));
            cyc(3);
            chk(16'(pwm[1]), 16'(m == 2 || (m == 0 && load[1])));
        end
        host.wr(brc_pkg::ADDR_CTRL + 8'h02, 16'h0c00);
        host.wr(brc_pkg::ADDR_CTRL + 8'h03, 16'h0c12);
        host.wr(brc_pkg::ADDR_CTRL + 8'h04, 16'h0c40);
        seq(1'b1, 4'h3);
        chk(16'(on[4:2]), 16'h0003);
        rx(brc_pkg::ADDR_CTRL + 8'h03, 16'h0c11);
        seq(1'b0, 4'h3);
        chk(16'(on[4:2]), 16'h0002);
        rx(brc_pkg::ADDR_CTRL + 8'h03, 16'h0c13);
        pin_set(1'b1);
        pin_set(1'b0);
        @(posedge ref_clk_i) pin[0] <= 1'b1;
        @(posedge ref_clk_i);
        host.wr(brc_pkg::ADDR_CTRL + 8'h04, 16'h0c40);
        cyc(2);
        chk(16'(on[4]), 16'h0000);
        rx(brc_pkg::ADDR_STATUS, 16'h04c0);
        host.wr(brc_pkg::ADDR_GLOBAL, 16'h003f);
        seq(1'b1, 4'h0);
        chk(16'(on), 16'h002b);
        rx(brc_pkg::ADDR_CTRL, 16'h0009);
        host.wr(brc_pkg::ADDR_GLOBAL, 16'h003b);
        seq(1'b1, 4'h0);
        chk(16'(on), 16'h0008);
        rx(brc_pkg::ADDR_CTRL, 16'h0008);
        @(posedge ref_clk_i) otp <= 1'b1;
        @(posedge ref_clk_i) otp <= 1'b0;
        cyc(2);
        rx(brc_pkg::ADDR_VOLT_A, 16'h0046);
        @(posedge ref_clk_i) rmode <= 1'b1;
        cyc(3);
        chk(16'(on), 16'h0000);
        cyc(2);
        summarize();
    end
endmodule // testbench
